// file: logic/ecbm_master.sv
// External control bus master: muxed address/data transfers, sideband routing
// Function
// - Address and data share one 32-bit two-way bus, address phase then data phase.
// - Bus clock out runs at half the internal clock; far end uses its edge.
// - Transceiver direction is 0 while sourcing, 1 while receiving.
// - Read/write output tells the far end the kind of transfer.
// - Request rises when an internal access hits the external address space.
// - Request drops two bus cycles after the data phase unless wait is held.
// - Returning read data is captured and presented on the internal bus.
// - A dedicated reset output resets elements on the external bus.
// - The far interrupt input is routed to the processor interrupt logic.
// - Two independent DMA request inputs, channels A and B, active high.
`timescale 1ns/1ps
module ecbm_master (
  // Clock and reset
  input  logic                           clk,
  input  logic                           rst,
  // Internal control bus
  input  ecbm_pkg::ecbm_req_s            cb_req,
  output ecbm_pkg::ecbm_rsp_s            cb_rsp,
  // Routed sideband requests
  output logic                           ext_irq,
  output logic                           dma_req_a_int,
  output logic                           dma_req_b_int,
  // External control bus pins
  input  logic [ecbm_pkg::AD_W-1:0]      ctl_bus_addr_data_in,
  output logic [ecbm_pkg::AD_W-1:0]      ctl_bus_addr_data_out,
  output logic                           ctl_bus_addr_data_oe_n,
  output logic                           ctl_bus_clock_out,
  output logic                           ctl_bus_xcvr_dir,
  output logic                           ctl_bus_read_not_write,
  output logic                           ctl_bus_xfer_request,
  output logic                           ctl_bus_reset_n,
  input  logic                           ctl_bus_wait_n,
  input  logic                           ctl_bus_irq_n,
  input  logic                           ext_dma_req_a,
  input  logic                           ext_dma_req_b
);

  ecbm_pkg::ecbm_state_e state;
  ecbm_pkg::ecbm_state_e next_state;
  logic [ecbm_pkg::AD_W-1:0]      ad_s;
  logic [ecbm_pkg::SB_W-1:0]      sb_s;
  logic [ecbm_pkg::AD_W-1:0]      cur_wdata;
  logic                           cur_rnw;
  logic                           check_seen;
  logic [ecbm_pkg::RST_CNT_W-1:0] rst_cnt;

  // Pin inputs cross into the clk domain through three flops and a filter flop
  ecbm_sync #(.W(ecbm_pkg::AD_W), .RESET_VAL(ecbm_pkg::AD_IDLE)) u_ad_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (ctl_bus_addr_data_in),
    .sync_out (ad_s)
  );

  ecbm_sync #(.W(ecbm_pkg::SB_W), .RESET_VAL(ecbm_pkg::SB_RESET)) u_sb_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({ext_dma_req_b, ext_dma_req_a, ctl_bus_irq_n, ctl_bus_wait_n}),
    .sync_out (sb_s)
  );

  // Decoding
  wire tick     = ~ctl_bus_clock_out;
  wire space_hit = cb_req.addr[ecbm_pkg::SPACE_MSB:ecbm_pkg::SPACE_LSB] == ecbm_pkg::EXT_SPACE;
  wire busy_ack = cb_rsp.ack;
  // Only an idle master may start; valid stays high until the answer
  wire idle     = state == ecbm_pkg::ECBM_IDLE;
  wire start    = tick && idle && cb_req.valid && !busy_ack && space_hit && ctl_bus_reset_n;
  wire miss     = cb_req.valid && !busy_ack && !space_hit && state == ecbm_pkg::ECBM_IDLE;
  wire waiting  = !sb_s[ecbm_pkg::SB_WAIT];
  // Far end answers just after the data phase edge; four flops need a second check cycle
  wire next_check_seen = state == ecbm_pkg::ECBM_CHECK && (check_seen || tick);
  wire finish   = tick && state == ecbm_pkg::ECBM_CHECK && check_seen && !waiting;

  // Next transfer phase; each step waits for a bus clock rising edge
  always_comb
  begin
    next_state = state;
    unique case (state)
      ecbm_pkg::ECBM_IDLE:  if (start) next_state = ecbm_pkg::ECBM_ADDR;
      ecbm_pkg::ECBM_ADDR:  if (tick) next_state = ecbm_pkg::ECBM_DATA;
      ecbm_pkg::ECBM_DATA:  if (tick) next_state = ecbm_pkg::ECBM_CHECK;
      ecbm_pkg::ECBM_CHECK: if (finish) next_state = ecbm_pkg::ECBM_IDLE;
    endcase
  end

  // Pin values for the coming bus cycle
  wire enter_data = tick && state == ecbm_pkg::ECBM_ADDR;
  wire next_oe_n  = start ? 1'b0
                  : enter_data ? cur_rnw
                  : finish ? 1'b1 : ctl_bus_addr_data_oe_n;
  wire [ecbm_pkg::AD_W-1:0] next_ad = start ? cb_req.addr
                  : enter_data ? (cur_rnw ? ecbm_pkg::AD_IDLE : cur_wdata)
                  : ctl_bus_addr_data_out;
  wire next_req   = start ? 1'b1 : finish ? 1'b0 : ctl_bus_xfer_request;
  // Direction follows the drivers: receive whenever the bus is released
  wire next_dir   = next_oe_n ? ecbm_pkg::DIR_RECEIVE : ecbm_pkg::DIR_SOURCE;
  wire next_rst_n = rst_cnt == ecbm_pkg::RST_CNT_W'(ecbm_pkg::RST_HOLD_CYC);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctl_bus_clock_out <= 1'b0;
    else
      ctl_bus_clock_out <= ~ctl_bus_clock_out;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state                  <= ecbm_pkg::ECBM_IDLE;
      check_seen             <= 1'b0;
      cur_rnw                <= 1'b1;
      cur_wdata              <= ecbm_pkg::AD_IDLE;
      ctl_bus_read_not_write <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      check_seen <= next_check_seen;
      if (start)
      begin
        cur_rnw                <= cb_req.rnw;
        cur_wdata              <= cb_req.wdata;
        ctl_bus_read_not_write <= cb_req.rnw;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_bus_addr_data_out  <= ecbm_pkg::AD_IDLE;
      ctl_bus_addr_data_oe_n <= 1'b1;
      ctl_bus_xcvr_dir       <= ecbm_pkg::DIR_RECEIVE;
      ctl_bus_xfer_request   <= 1'b0;
    end
    else
    begin
      ctl_bus_addr_data_out  <= next_ad;
      ctl_bus_addr_data_oe_n <= next_oe_n;
      ctl_bus_xcvr_dir       <= next_dir;
      ctl_bus_xfer_request   <= next_req;
    end
  end

  // Answer; misses on the external space answer at once with an error
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cb_rsp <= '0;
    else
    begin
      cb_rsp.ack <= finish || miss;
      cb_rsp.err <= miss;
      if (finish && cur_rnw)
        cb_rsp.rdata <= ad_s;
    end
  end

  // Far-end reset held low for a fixed time after our own reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rst_cnt         <= '0;
      ctl_bus_reset_n <= 1'b0;
    end
    else
    begin
      if (!next_rst_n)
        rst_cnt <= rst_cnt + 1'b1;
      ctl_bus_reset_n <= next_rst_n;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_irq       <= 1'b0;
      dma_req_a_int <= 1'b0;
      dma_req_b_int <= 1'b0;
    end
    else
    begin
      ext_irq       <= !sb_s[ecbm_pkg::SB_IRQ];
      dma_req_a_int <= sb_s[ecbm_pkg::SB_DMA_A];
      dma_req_b_int <= sb_s[ecbm_pkg::SB_DMA_B];
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  clk_half_rate_a: assert property (ctl_bus_clock_out |=> !ctl_bus_clock_out ##1 ctl_bus_clock_out)
    else $error("bus clock not half rate");
  dir_follows_oe_a: assert property (ctl_bus_xcvr_dir == ctl_bus_addr_data_oe_n)
    else $error("direction disagrees with drivers");
  req_on_hit_a: assert property (start |=> ctl_bus_xfer_request && !ctl_bus_addr_data_oe_n
                                 && ctl_bus_addr_data_out == $past(cb_req.addr))
    else $error("request or address missing after hit");
  req_drop_a: assert property (finish |=> !ctl_bus_xfer_request && cb_rsp.ack)
    else $error("request not dropped at end");
  req_hold_a: assert property (tick && state == ecbm_pkg::ECBM_CHECK && waiting
                               |=> ctl_bus_xfer_request ##1 ctl_bus_xfer_request)
    else $error("request dropped while waiting");
  rnw_stable_a: assert property (ctl_bus_xfer_request && $past(ctl_bus_xfer_request)
                                 |-> $stable(ctl_bus_read_not_write))
    else $error("read/write changed mid transfer");
  read_data_a: assert property (finish && cur_rnw |=> cb_rsp.rdata == $past(ad_s))
    else $error("read data not captured");
  data_phase_a: assert property (enter_data |=> ctl_bus_addr_data_oe_n == cur_rnw
                                 && ctl_bus_xcvr_dir == cur_rnw)
    else $error("data phase drive wrong");
  far_reset_a: assert property (rst_cnt < ecbm_pkg::RST_CNT_W'(ecbm_pkg::RST_HOLD_CYC)
                                |=> !ctl_bus_reset_n)
    else $error("far reset released early");
  irq_route_a: assert property (##1 ext_irq == !$past(sb_s[ecbm_pkg::SB_IRQ]))
    else $error("interrupt not routed");
  dma_route_a: assert property (##1 dma_req_a_int == $past(sb_s[ecbm_pkg::SB_DMA_A])
                                && dma_req_b_int == $past(sb_s[ecbm_pkg::SB_DMA_B]))
    else $error("dma request not routed");

  read_done_c:  cover property (finish && cur_rnw);
  write_done_c: cover property (finish && !cur_rnw);
  stretched_c:  cover property (tick && state == ecbm_pkg::ECBM_CHECK && waiting);
  miss_c:       cover property (miss);

endmodule

// file: logic/ecbm_pkg.sv
// Package: constants and carrier types of the external control bus master
package ecbm_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int RST_HOLD_NS     = 320;
  localparam int RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W       = 5;

  // Bus geometry
  localparam int AD_W            = 32;
  localparam int SPACE_MSB       = 31;
  localparam int SPACE_LSB       = 28;
  localparam logic [3:0] EXT_SPACE = 4'h8;
  localparam logic [AD_W-1:0] AD_IDLE = 32'h0000_0000;

  // Transceiver direction codes
  localparam logic DIR_SOURCE    = 1'b0;
  localparam logic DIR_RECEIVE   = 1'b1;

  // Sideband inputs, in synchroniser bit order
  localparam int SB_W            = 4;
  localparam int SB_WAIT         = 0;
  localparam int SB_IRQ          = 1;
  localparam int SB_DMA_A        = 2;
  localparam int SB_DMA_B        = 3;
  localparam logic [SB_W-1:0] SB_RESET = 4'h3;

  // Transfer phases, Gray coded along the path
  typedef enum logic [1:0] {
    ECBM_IDLE  = 2'b00,
    ECBM_ADDR  = 2'b01,
    ECBM_DATA  = 2'b11,
    ECBM_CHECK = 2'b10
  } ecbm_state_e;

  // Internal control bus request, held until answered
  typedef struct packed {
    logic            valid;
    logic            rnw;
    logic [AD_W-1:0] addr;
    logic [AD_W-1:0] wdata;
  } ecbm_req_s;

  // Internal control bus answer
  typedef struct packed {
    logic            ack;
    logic            err;
    logic [AD_W-1:0] rdata;
  } ecbm_rsp_s;

endpackage

// file: logic/ecbm_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ecbm_sync #(
  parameter int          W          = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  logic         clk,
  input  logic         rst,
  // Asynchronous input and filtered result
  input  logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);
  wire  [W-1:0] next_sync_out = (agree & stage3) | (~agree & sync_out);

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1   <= RESET_VAL;
      stage2   <= RESET_VAL;
      stage3   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// file: test/ecbm_far_model.sv
// Far element on the external control bus: decodes frames, answers reads, stretches with wait
`timescale 1ns/1ps
module ecbm_far_model (
  // Device pins
  input  logic        ctl_bus_clock_out,
  input  logic        ctl_bus_xfer_request,
  input  logic        ctl_bus_read_not_write,
  input  logic        ctl_bus_xcvr_dir,
  input  logic [31:0] ctl_bus_addr_data_out,
  input  logic        ctl_bus_addr_data_oe_n,
  // Resolved bus and wait
  output logic [31:0] ctl_bus_addr_data_in,
  output logic        ctl_bus_wait_n,
  // Wait length in bus cycles, set by the bench
  input  logic [3:0]  wait_len
);
  logic [31:0] far_val, last_val, addr_seen, wdata_seen;
  logic        far_drive, rnw_seen, dir_addr, dir_data, req_d;
  int          phase, req_cycles, wait_left;

  // Released bus shows the inverse of its last value, never a stale copy
  assign ctl_bus_addr_data_in = !ctl_bus_addr_data_oe_n ? ctl_bus_addr_data_out :
                                far_drive ? far_val : ~last_val;
  always @(ctl_bus_addr_data_in)
    if (!ctl_bus_addr_data_oe_n || far_drive)
      last_val = ctl_bus_addr_data_in;

  initial
  begin
    far_drive = 1'b0; last_val = 32'h0000_0000; req_d = 1'b0;
    wait_left = 0; phase = 0; req_cycles = 0; ctl_bus_wait_n = 1'b1;
  end

  // Sampled just after the bus clock edge, when device pins have settled
  always @(posedge ctl_bus_clock_out)
  begin
    #1;
    if (ctl_bus_xfer_request && !req_d)
    begin
      phase = 1; req_cycles = 1; addr_seen = ctl_bus_addr_data_in;
      rnw_seen = ctl_bus_read_not_write; dir_addr = ctl_bus_xcvr_dir;
    end
    else if (ctl_bus_xfer_request)
    begin
      req_cycles++;
      if (phase == 1)
      begin
        dir_data = ctl_bus_xcvr_dir;
        if (!rnw_seen)
          wdata_seen = ctl_bus_addr_data_in;
        far_val = ~addr_seen; far_drive = rnw_seen; wait_left = wait_len;
      end
      else if (wait_left > 0)
        wait_left--;
      phase++;
    end
    else
    begin
      far_drive = 1'b0; wait_left = 0;
    end
    ctl_bus_wait_n = (wait_left == 0);
    req_d = ctl_bus_xfer_request;
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench of the external control bus master
`timescale 1ns/1ps
module tb_top;
  logic                clk, rst, ext_irq, dma_a, dma_b, oe_n, bclk, dir, rnw, req;
  logic                rst_n, wait_n, irq_n, dreq_a, dreq_b, b, req_hit;
  logic [31:0]         ad_in, ad_out;
  logic [3:0]          wait_len;
  ecbm_pkg::ecbm_req_s cb_req;
  ecbm_pkg::ecbm_rsp_s cb_rsp, got;
  int                  miscompares, check_count;

  ecbm_master u_dut (.clk(clk), .rst(rst), .cb_req(cb_req), .cb_rsp(cb_rsp),
    .ext_irq(ext_irq), .dma_req_a_int(dma_a), .dma_req_b_int(dma_b),
    .ctl_bus_addr_data_in(ad_in), .ctl_bus_addr_data_out(ad_out),
    .ctl_bus_addr_data_oe_n(oe_n), .ctl_bus_clock_out(bclk), .ctl_bus_xcvr_dir(dir),
    .ctl_bus_read_not_write(rnw), .ctl_bus_xfer_request(req), .ctl_bus_reset_n(rst_n),
    .ctl_bus_wait_n(wait_n), .ctl_bus_irq_n(irq_n), .ext_dma_req_a(dreq_a),
    .ext_dma_req_b(dreq_b));

  ecbm_far_model u_far (.ctl_bus_clock_out(bclk), .ctl_bus_xfer_request(req),
    .ctl_bus_read_not_write(rnw), .ctl_bus_xcvr_dir(dir), .ctl_bus_addr_data_out(ad_out),
    .ctl_bus_addr_data_oe_n(oe_n), .ctl_bus_addr_data_in(ad_in), .ctl_bus_wait_n(wait_n),
    .wait_len(wait_len));

  always #10 clk = ~clk;

  task automatic conclude();
    $display("Counts: checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One bus transfer; valid held until ack, waits are bounded
  task automatic xfer(input logic r, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] w);
    int n;
    n = 0;
    req_hit = 1'b0;
    wait_len = w;
    cb_req = '{valid: 1'b1, rnw: r, addr: a, wdata: d};
    while (cb_rsp.ack !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      if (req === 1'b1)
        req_hit = 1'b1;
      n++;
    end
    if (n == 200)
    begin
      miscompares++;
      conclude();
    end
    got = cb_rsp;
    cb_req.valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk(rst_n, 0);
    chk(bclk, 0);
    chk(dir, 1);
    chk(req, 0);
    chk(oe_n, 1);
    rst = 1'b0;
    repeat (ecbm_pkg::RST_HOLD_CYC) @(negedge clk);
    chk(rst_n, 0);
    @(negedge clk);
    chk(rst_n, 1);
    b = bclk;
    @(negedge clk);
    chk(bclk, !b);
    $display("test reset done");
  endtask

  task automatic t_write();
    xfer(1'b0, 32'h8000_0010, 32'h1234_5678, 4'h0);
    chk(got.err, 0);
    chk(u_far.addr_seen, 32'h8000_0010);
    chk(u_far.rnw_seen, 0);
    chk(u_far.dir_addr, 0);
    chk(u_far.dir_data, 0);
    chk(u_far.wdata_seen, 32'h1234_5678);
    chk(u_far.req_cycles, 4);
    $display("test write done");
  endtask

  task automatic t_read(input logic [3:0] w);
    xfer(1'b1, 32'h8ABC_0020, 32'h0000_0000, w);
    chk(got.rdata, ~32'h8ABC_0020);
    chk(u_far.rnw_seen, 1);
    chk(u_far.dir_addr, 0);
    chk(u_far.dir_data, 1);
    chk(u_far.req_cycles > (w == 0 ? 3 : 4), 1);
    if (w == 0)
      chk(u_far.req_cycles, 4);
    $display("test read done, wait %0d", w);
  endtask

  task automatic t_miss();
    xfer(1'b1, 32'h1000_0000, 32'h0000_0000, 4'h0);
    chk(got.err, 1);
    chk(req_hit, 0);
    $display("test miss done");
  endtask

  task automatic t_side();
    irq_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(ext_irq, 1);
    irq_n = 1'b1;
    dreq_a = 1'b1;
    repeat (6) @(negedge clk);
    chk({ext_irq, dma_a, dma_b}, 3'b010);
    dreq_a = 1'b0;
    dreq_b = 1'b1;
    repeat (6) @(negedge clk);
    chk({dma_a, dma_b}, 2'b01);
    dreq_b = 1'b0;
    $display("test sideband done");
  endtask

  initial
  begin
    clk = 1'b0; rst = 1'b1; irq_n = 1'b1; dreq_a = 1'b0; dreq_b = 1'b0; wait_len = 4'h0;
    miscompares = 0; check_count = 0;
    cb_req = '{valid: 1'b0, rnw: 1'b1, addr: 32'h0000_0000, wdata: 32'h0000_0000};
    t_reset();
    t_write();
    t_read(4'h0);
    t_read(4'h3);
    t_write();
    t_miss();
    t_side();
    conclude();
  end
endmodule
